// ### include/bfc_pkg.sv
// Package holding constants and types of the buck fault and frequency control block
package bfc_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int          CLK_HZ          = 10_000_000;
	localparam int          BUCK_ENABLE_PIN_RETRY_MS = 2000;
	localparam int          BUCK_ENABLE_PIN_RETRY_CYC = (CLK_HZ / 1000) * BUCK_ENABLE_PIN_RETRY_MS;
	localparam int          FAULT_RETRY_MS  = 100;
	localparam int          FAULT_RETRY_CYC = (CLK_HZ / 1000) * FAULT_RETRY_MS;
	localparam int          DROOP_MS        = 16;
	localparam int          DROOP_CYC       = (CLK_HZ / 1000) * DROOP_MS;
	localparam int          TMR_W           = 26;
	localparam logic [2:0]  PEAK_RUN_LIMIT  = 3'h4;
	// ----------------------------------------------------------------
	// Frequency select: 0 is the fastest (2.2 MHz) setting, 7 the slowest
	// ----------------------------------------------------------------
	localparam logic [2:0]  FSEL_POR        = 3'h0;
	localparam logic [2:0]  DC_LIMIT_SELECT_THERMAL    = 3'h1;
	localparam logic [2:0]  DC_LIMIT_SELECT_MIN        = 3'h0;
	localparam logic [1:0]  ADV_MIN         = 2'h0;
	// Half-period of each oscillator setting in system clock cycles (coarse at 10 MHz)
	localparam logic [7:0]  HALF_P0 = 8'h02;
	localparam logic [7:0]  HALF_P1 = 8'h03;
	localparam logic [7:0]  HALF_P2 = 8'h04;
	localparam logic [7:0]  HALF_P3 = 8'h05;
	localparam logic [7:0]  HALF_P4 = 8'h07;
	localparam logic [7:0]  HALF_P5 = 8'h0a;
	localparam logic [7:0]  HALF_P6 = 8'h0e;
	localparam logic [7:0]  HALF_P7 = 8'h10;
	// Sync clock tolerance window in percent
	localparam int          SYNC_TOL_PCT    = 20;
	localparam logic [7:0]  DITHER_MAX      = 8'h01;
	// ----------------------------------------------------------------
	// Converter states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		BFC_OFF   = 5'b00001,
		BFC_RUN   = 5'b00010,
		BFC_FAULT = 5'b00100,
		BFC_RETRY = 5'b01000,
		BFC_SHORTB = 5'b10000
	} bfc_state_e;
endpackage : bfc_pkg

// ### core/bfc_sync2.sv
// Two flip-flop synchroniser for one pin level
`timescale 1ns/100ps
module bfc_sync2
	import bfc_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic meta;
	// ----------------------------------------------------------------
	// Stage one is read only by stage two
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta  <= 1'b0;
			q_out <= 1'b0;
		end else begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule : bfc_sync2

// ### core/bfc_retry_timer.sv
// Loadable down-counter used for the enable and fault retry timers
`timescale 1ns/100ps
module bfc_retry_timer
	import bfc_pkg::*;
(
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             start_in,
	input  wire logic [TMR_W-1:0] load_in,
	output logic                  busy_out
);
	logic [TMR_W-1:0] count;
	// ----------------------------------------------------------------
	// A new start reloads, so a fresh fault restarts the wait
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count <= '0;
		end else if (start_in) begin
			count <= load_in;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end
	assign busy_out = (count != '0);
endmodule : bfc_retry_timer

// ### core/bfc_core.sv
// Fault supervision, retry timing, oscillator, sync and thermal foldback of the buck
`timescale 1ns/100ps
// Behaviour
// - UV, OV or overtemperature resets the buck; retry timer runs after clearing.
// - Enable pin falling starts a 2 s timer holding the buck off.
// - Three-bit frequency select picks one of eight settings; reset value is 2.2 MHz.
// - Standalone variant loads frequency select from strap one at startup.
// - Sync as output forbids skip mode and drives inverted oscillator clock.
// - Sync input high or clocked forces PWM; low allows skip for Type-A only.
// - External sync within 20 percent of programmed frequency is followed.
// - Forced PWM keeps switching at fixed frequency at every load.
// - Spread-spectrum enable bit is preloaded from strap one on both variants.
// - Dithering lowers frequency by 3 to 20 percent (one extra cycle per period), internal oscillator only.
// - Peak or DC limit exceeded turns the high-side switch off at once.
// - I2C variant: 16 ms droop limit sets flag, fault pin; resets unless inhibited.
// - Standalone: 16 ms droop limit asserts fault pin, no reset, current source.
// - Below 2.0 V with DC limit or four peak cycles resets immediately.
// - Short to ground or UV resets, flags fault, retries soft-start repeatedly.
// - Short to battery stops switching, drops isolation gate, flags, holds while present.
// - Thermal shutdown above 165 C, restart after cooling 10 C.
// - Standalone thermal warning lowers limit and advertisement one step.
// - I2C thermal warning lowers advertisement one step, forces 1.62 A limit.
// - Foldback never resets the bus nor changes detection mode.
// - Three-bit DC limit select; standalone offers a strap-chosen subset.
// - Straps are sampled only at power-on reset.
module bfc_core
	import bfc_pkg::*;
#(
	parameter int BUCK_ENABLE_PIN_RETRY = BUCK_ENABLE_PIN_RETRY_CYC,
	parameter int FAULT_RETRY  = FAULT_RETRY_CYC,
	parameter int DROOP_TIME   = DROOP_CYC
)(
	input  wire logic       SYS_CLK_IN,
	input  wire logic       RST_IN,
	input  wire logic       STANDALONE_IN,
	input  wire logic       BUCK_ENABLE_PIN_IN,
	input  wire logic       UV_FAULT_IN,
	input  wire logic       OV_FAULT_IN,
	input  wire logic       OVERTEMP_IN,
	input  wire logic       THERMAL_WARN_IN,
	input  wire logic       SHORT_BATT_IN,
	input  wire logic       PEAK_LIMIT_IN,
	input  wire logic       DC_LIMIT_IN,
	input  wire logic       OUT_BELOW_RESET_IN,
	input  wire logic       OUT_BELOW_2V_IN,
	input  wire logic       SYNC_IN,
	input  wire logic       TYPE_A_IN,
	input  wire logic [2:0] STRAP_PIN_ONE_FSEL_IN,
	input  wire logic       STRAP_PIN_ONE_SS_IN,
	input  wire logic       STRAP_PIN_ONE_DIR_IN,
	input  wire logic [2:0] STRAP_PIN_THREE_DC_LIMIT_SELECT_IN,
	input  wire logic [1:0] STRAP_PIN_THREE_ADV_IN,
	input  wire logic       CFG_WE_IN,
	input  wire logic [2:0] OSC_FREQ_SELECT_IN,
	input  wire logic       SS_ENABLE_IN,
	input  wire logic       SYNC_DIR_IN_IN,
	input  wire logic [2:0] DC_LIMIT_SELECT_IN,
	input  wire logic [1:0] SOURCE_CURRENT_ADVERT_IN,
	input  wire logic       DROOP_RESET_INHIBIT_IN,
	input  wire logic       FLAG_CLEAR_IN,
	output logic            BUCK_RUN_OUT,
	output logic            HIGH_SIDE_OFF_OUT,
	output logic            ISOLATION_GATE_DRIVE_OUT,
	output logic            FAULT_N_OUT,
	output logic            OVERCURRENT_DROOP_FLAG_OUT,
	output logic            SHORT_FAULT_FLAG_OUT,
	output logic            FORCED_PWM_OUT,
	output logic            SYNC_OUT,
	output logic            SYNC_OE_OUT,
	output logic            SW_CLK_OUT,
	output logic [2:0]      OSC_FREQ_SELECT_OUT,
	output logic [2:0]      EFF_DC_LIMIT_OUT,
	output logic [1:0]      EFF_ADVERT_OUT
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic en_s, uv_s, ov_s, ot_s, tw_s, sb_s, pk_s, dc_s, lo_s, l2_s, sy_s;
	bfc_sync2 u_s_en (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .d_in(BUCK_ENABLE_PIN_IN), .q_out(en_s));
	bfc_sync2 u_s_uv (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .d_in(UV_FAULT_IN), .q_out(uv_s));
	bfc_sync2 u_s_ov (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .d_in(OV_FAULT_IN), .q_out(ov_s));
	bfc_sync2 u_s_ot (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .d_in(OVERTEMP_IN), .q_out(ot_s));
	bfc_sync2 u_s_tw (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .d_in(THERMAL_WARN_IN), .q_out(tw_s));
	bfc_sync2 u_s_sb (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .d_in(SHORT_BATT_IN), .q_out(sb_s));
	bfc_sync2 u_s_pk (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .d_in(PEAK_LIMIT_IN), .q_out(pk_s));
	bfc_sync2 u_s_dc (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .d_in(DC_LIMIT_IN), .q_out(dc_s));
	bfc_sync2 u_s_lo (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .d_in(OUT_BELOW_RESET_IN), .q_out(lo_s));
	bfc_sync2 u_s_l2 (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .d_in(OUT_BELOW_2V_IN), .q_out(l2_s));
	bfc_sync2 u_s_sy (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .d_in(SYNC_IN), .q_out(sy_s));

	// ----------------------------------------------------------------
	// Configuration: straps caught once after reset release
	// ----------------------------------------------------------------
	logic       strap_done;
	logic [2:0] fsel;
	logic       ss_en, dir_in, inhibit;
	logic [2:0] dc_limit_select_sel;
	logic [1:0] adv_sel;
	// Straps only read on the first cycle after reset; later pin changes are ignored
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			strap_done <= 1'b0;
			fsel       <= FSEL_POR;
			ss_en      <= 1'b0;
			dir_in     <= 1'b1;
			dc_limit_select_sel   <= DC_LIMIT_SELECT_MIN;
			adv_sel    <= ADV_MIN;
			inhibit    <= 1'b0;
		end else if (!strap_done) begin
			strap_done <= 1'b1;
			ss_en      <= STRAP_PIN_ONE_SS_IN;
			dir_in     <= STRAP_PIN_ONE_DIR_IN;
			if (STANDALONE_IN) begin
				fsel     <= STRAP_PIN_ONE_FSEL_IN;
				dc_limit_select_sel <= STRAP_PIN_THREE_DC_LIMIT_SELECT_IN;
				adv_sel  <= STRAP_PIN_THREE_ADV_IN;
			end
		end else if (CFG_WE_IN && !STANDALONE_IN) begin
			fsel     <= OSC_FREQ_SELECT_IN;
			ss_en    <= SS_ENABLE_IN;
			dir_in   <= SYNC_DIR_IN_IN;
			dc_limit_select_sel <= DC_LIMIT_SELECT_IN;
			adv_sel  <= SOURCE_CURRENT_ADVERT_IN;
			inhibit  <= DROOP_RESET_INHIBIT_IN;
		end
	end

	// ----------------------------------------------------------------
	// Thermal foldback: changes limits only, never state or detection
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			EFF_DC_LIMIT_OUT <= DC_LIMIT_SELECT_MIN;
			EFF_ADVERT_OUT   <= ADV_MIN;
		end else begin
			EFF_DC_LIMIT_OUT <= dc_limit_select_sel;
			EFF_ADVERT_OUT   <= adv_sel;
			if (tw_s) begin
				EFF_ADVERT_OUT <= (adv_sel == ADV_MIN) ? ADV_MIN : adv_sel - 2'h1;
				if (STANDALONE_IN)
					EFF_DC_LIMIT_OUT <= (dc_limit_select_sel == DC_LIMIT_SELECT_MIN) ? DC_LIMIT_SELECT_MIN : dc_limit_select_sel - 3'h1;
				else
					EFF_DC_LIMIT_OUT <= DC_LIMIT_SELECT_THERMAL;
			end
		end
	end

	// ----------------------------------------------------------------
	// Internal oscillator with optional dither
	// ----------------------------------------------------------------
	logic [7:0] half_p, osc_cnt, dith;
	logic       osc, osc_tick, ext_mode;
	always_comb begin
		case (fsel)
			3'h0: half_p = HALF_P0;
			3'h1: half_p = HALF_P1;
			3'h2: half_p = HALF_P2;
			3'h3: half_p = HALF_P3;
			3'h4: half_p = HALF_P4;
			3'h5: half_p = HALF_P5;
			3'h6: half_p = HALF_P6;
			default: half_p = HALF_P7;
		endcase
	end
	// Dither stretches alternate half periods; coarse at this clock, bounded by DITHER_MAX
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			osc_cnt <= 8'h00;
			osc     <= 1'b0;
			dith    <= 8'h00;
		end else if (osc_cnt + 8'h01 >= half_p + dith) begin
			osc_cnt <= 8'h00;
			osc     <= ~osc;
			dith    <= (ss_en && !ext_mode && dith == 8'h00) ? DITHER_MAX : 8'h00;
		end else begin
			osc_cnt <= osc_cnt + 8'h01;
		end
	end
	assign osc_tick = (osc_cnt == 8'h00);

	// ----------------------------------------------------------------
	// Sync pin: edge period measurement and mode selection
	// ----------------------------------------------------------------
	logic       sy_d, sy_rise;
	logic [9:0] per_cnt, lo_bound, hi_bound;
	logic [1:0] good_edges;
	assign sy_rise  = sy_s & ~sy_d;
	assign lo_bound = 10'((({2'h0, half_p} << 1) * (100 - SYNC_TOL_PCT)) / 100);
	assign hi_bound = 10'((({2'h0, half_p} << 1) * (100 + SYNC_TOL_PCT)) / 100);
	assign ext_mode = dir_in && (good_edges == 2'h3);
	// Three in-range periods in a row are needed before following the external clock
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			sy_d       <= 1'b0;
			per_cnt    <= 10'h000;
			good_edges <= 2'h0;
		end else begin
			sy_d <= sy_s;
			if (sy_rise) begin
				per_cnt <= 10'h000;
				if (per_cnt + 10'h001 >= lo_bound && per_cnt + 10'h001 <= hi_bound)
					good_edges <= (good_edges == 2'h3) ? 2'h3 : good_edges + 2'h1;
				else
					good_edges <= 2'h0;
			end else if (per_cnt > hi_bound) begin
				good_edges <= 2'h0;
			end else begin
				per_cnt <= per_cnt + 10'h001;
			end
		end
	end
	// Sync direction, skip permission and the switching clock
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			SYNC_OE_OUT    <= 1'b0;
			SYNC_OUT       <= 1'b0;
			FORCED_PWM_OUT <= 1'b1;
			SW_CLK_OUT     <= 1'b0;
		end else begin
			SYNC_OE_OUT <= ~dir_in;
			SYNC_OUT    <= dir_in ? 1'b0 : ~osc;
			// Skip only with input direction, low pin, no clock and Type-A
			FORCED_PWM_OUT <= !dir_in || sy_s || ext_mode || !TYPE_A_IN;
			SW_CLK_OUT  <= ext_mode ? sy_s : osc;
		end
	end

	// ----------------------------------------------------------------
	// Current limit: peak run and droop timer
	// ----------------------------------------------------------------
	bfc_state_e       state, next_state;
	logic [2:0]       peak_run;
	logic [TMR_W-1:0] droop_cnt;
	logic             limit_now, droop_hit, hard_short;
	assign limit_now  = pk_s | dc_s;
	assign droop_hit  = (droop_cnt == TMR_W'(DROOP_TIME));
	assign hard_short = l2_s && (dc_s || peak_run >= PEAK_RUN_LIMIT);
	// Peak events counted once per switching cycle; a clean cycle restarts the count
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			peak_run <= 3'h0;
		end else if (osc_tick && osc) begin
			peak_run <= pk_s ? ((peak_run >= PEAK_RUN_LIMIT) ? peak_run : peak_run + 3'h1) : 3'h0;
		end
	end
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			droop_cnt <= '0;
		end else if (limit_now && lo_s && !l2_s && state == BFC_RUN) begin
			droop_cnt <= droop_hit ? droop_cnt : droop_cnt + 1'b1;
		end else begin
			droop_cnt <= '0;
		end
	end
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) HIGH_SIDE_OFF_OUT <= 1'b1;
		else HIGH_SIDE_OFF_OUT <= limit_now || state != BFC_RUN;
	end

	// ----------------------------------------------------------------
	// Retry timers
	// ----------------------------------------------------------------
	logic en_d, en_fall, en_busy, flt_busy, flt_start, fault_now, droop_reset;
	assign en_fall     = en_d & ~en_s;
	assign fault_now   = uv_s | ov_s | ot_s;
	assign droop_reset = droop_hit && !STANDALONE_IN && !inhibit;
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) en_d <= 1'b0;
		else en_d <= en_s;
	end
	bfc_retry_timer u_en_tmr (
		.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .start_in(en_fall),
		.load_in(TMR_W'(BUCK_ENABLE_PIN_RETRY)), .busy_out(en_busy));
	bfc_retry_timer u_flt_tmr (
		.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .start_in(flt_start),
		.load_in(TMR_W'(FAULT_RETRY)), .busy_out(flt_busy));

	// ----------------------------------------------------------------
	// Converter state machine
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		flt_start  = 1'b0;
		case (state)
			BFC_OFF:
				if (sb_s) next_state = BFC_SHORTB;
				else if (fault_now) next_state = BFC_FAULT;
				else if (en_s && !en_busy && !flt_busy && strap_done) next_state = BFC_RUN;
			BFC_RUN:
				if (sb_s) next_state = BFC_SHORTB;
				else if (fault_now || hard_short || droop_reset) next_state = BFC_FAULT;
				else if (!en_s) next_state = BFC_OFF;
			BFC_FAULT:
				if (sb_s) next_state = BFC_SHORTB;
				else if (!fault_now) begin
					next_state = BFC_RETRY;
					flt_start  = 1'b1;
				end
			BFC_RETRY:
				if (sb_s) next_state = BFC_SHORTB;
				else if (fault_now) next_state = BFC_FAULT;
				else if (!flt_busy) next_state = BFC_OFF;
			BFC_SHORTB:
				if (!sb_s) begin
					next_state = BFC_RETRY;
					flt_start  = 1'b1;
				end
			default: next_state = BFC_OFF;
		endcase
	end
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) state <= BFC_OFF;
		else state <= next_state;
	end

	// ----------------------------------------------------------------
	// Outputs and sticky flags; a set in the clear cycle wins
	// ----------------------------------------------------------------
	logic droop_evt, short_evt;
	assign droop_evt = droop_hit && state == BFC_RUN;
	assign short_evt = (state == BFC_RUN && (uv_s || hard_short)) || sb_s;
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			OVERCURRENT_DROOP_FLAG_OUT <= 1'b0;
			SHORT_FAULT_FLAG_OUT       <= 1'b0;
		end else begin
			if (droop_evt && !STANDALONE_IN) OVERCURRENT_DROOP_FLAG_OUT <= 1'b1;
			else if (FLAG_CLEAR_IN) OVERCURRENT_DROOP_FLAG_OUT <= 1'b0;
			if (short_evt) SHORT_FAULT_FLAG_OUT <= 1'b1;
			else if (FLAG_CLEAR_IN) SHORT_FAULT_FLAG_OUT <= 1'b0;
		end
	end
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			BUCK_RUN_OUT             <= 1'b0;
			ISOLATION_GATE_DRIVE_OUT <= 1'b0;
			FAULT_N_OUT              <= 1'b1;
			OSC_FREQ_SELECT_OUT      <= FSEL_POR;
		end else begin
			BUCK_RUN_OUT             <= (next_state == BFC_RUN);
			ISOLATION_GATE_DRIVE_OUT <= (next_state != BFC_SHORTB) && strap_done;
			// Fault pin low while droop or short faults are flagged, or short present
			FAULT_N_OUT <= !(droop_evt || short_evt || state == BFC_SHORTB
				|| OVERCURRENT_DROOP_FLAG_OUT || SHORT_FAULT_FLAG_OUT);
			OSC_FREQ_SELECT_OUT <= fsel;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_buck_enable_pin_hold;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) en_fall |=> !BUCK_RUN_OUT [*8];
	endproperty
	a_buck_enable_pin_hold: assert property (p_buck_enable_pin_hold) else $error("buck ran after enable fall");
	property p_fault_off;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) fault_now |=> ##1 !BUCK_RUN_OUT;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("buck on during fault");
	property p_retry_hold;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) flt_start |=> !BUCK_RUN_OUT [*4];
	endproperty
	a_retry_hold: assert property (p_retry_hold) else $error("retry timer ignored");
	property p_sync_out;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) !dir_in |=> SYNC_OE_OUT && FORCED_PWM_OUT;
	endproperty
	a_sync_out: assert property (p_sync_out) else $error("sync output mode wrong");
	property p_sync_hi;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) (dir_in && sy_s) |=> FORCED_PWM_OUT;
	endproperty
	a_sync_hi: assert property (p_sync_hi) else $error("high sync did not force PWM");
	property p_limit_off;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) limit_now |=> HIGH_SIDE_OFF_OUT;
	endproperty
	a_limit_off: assert property (p_limit_off) else $error("high side not off at limit");
	property p_shortb;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) sb_s |=> (!ISOLATION_GATE_DRIVE_OUT && !FAULT_N_OUT);
	endproperty
	a_shortb: assert property (p_shortb) else $error("short to battery not handled");
	property p_hard_short;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) (state == BFC_RUN && hard_short) |=> state == BFC_FAULT;
	endproperty
	a_hard_short: assert property (p_hard_short) else $error("low output short not reset");
	property p_sa_no_reset;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
			(STANDALONE_IN && droop_evt && !fault_now && !hard_short && !sb_s && en_s) |=> state == BFC_RUN;
	endproperty
	a_sa_no_reset: assert property (p_sa_no_reset) else $error("standalone reset on droop");
	property p_foldback;
		@(posedge SYS_CLK_IN) disable iff (RST_IN) (tw_s && !STANDALONE_IN) |=> EFF_DC_LIMIT_OUT == DC_LIMIT_SELECT_THERMAL;
	endproperty
	a_foldback: assert property (p_foldback) else $error("thermal limit not forced");
endmodule : bfc_core

// ### verif/bfc_load_model.sv
// Behavioural buck power stage and port load seen by the control core
`timescale 1ns/100ps
module bfc_load_model (
	input  wire logic       clk_in,
	input  wire logic       run_in,
	input  wire logic [1:0] load_mode_in,
	output logic            dc_limit_out,
	output logic            below_reset_out,
	output logic            below_2v_out,
	output logic            uv_out
);
	// Mode 1 droops the rail between thresholds, mode 2 shorts it; a stopped buck rail decays to 0
	always_ff @(posedge clk_in) begin
		dc_limit_out    <= run_in && load_mode_in != 2'h0;
		below_reset_out <= !run_in || load_mode_in != 2'h0;
		below_2v_out    <= !run_in || load_mode_in == 2'h2;
		uv_out          <= run_in && load_mode_in == 2'h2;
	end
endmodule : bfc_load_model

// ### verif/testbench.sv
// Self-checking bench for the buck fault and frequency control core
`timescale 1ns/100ps
module testbench;
	import bfc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, en = 1'b1, sb = 1'b0, warn = 1'b0, we = 1'b0, clr = 1'b0;
	logic sa = 1'b0, ov = 1'b0, ot = 1'b0, sync = 1'b0, typea = 1'b1, cdir = 1'b1, ss = 1'b0, cinh = 1'b0;
	logic [2:0] s1f = 3'h0, cf = 3'h3;
	logic [1:0] mode = 2'h0;
	logic run, hso, gate, fault_n, droop_f, short_f, dcl, brst, b2v, uv, fpwm, sync_o, soe, swclk;
	logic [2:0] fsel, eff_lim;
	logic [1:0] eff_adv;
	int bad_count = 0, cmp_count = 0, cycles = 0;
	// ----------------------------------------------------------------
	// Clock, timeout and design
	// ----------------------------------------------------------------
	always #50 clk = ~clk;
	// Hang guard well above the longest scenario
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			end_sim();
		end
	end
	bfc_load_model load (.clk_in(clk), .run_in(run), .load_mode_in(mode), .dc_limit_out(dcl),
		.below_reset_out(brst), .below_2v_out(b2v), .uv_out(uv));
	bfc_core #(.BUCK_ENABLE_PIN_RETRY(20), .FAULT_RETRY(10), .DROOP_TIME(30)) dut (.SYS_CLK_IN(clk), .RST_IN(rst),
		.STANDALONE_IN(sa), .BUCK_ENABLE_PIN_IN(en), .UV_FAULT_IN(uv), .OV_FAULT_IN(ov),
		.OVERTEMP_IN(ot), .THERMAL_WARN_IN(warn), .SHORT_BATT_IN(sb), .PEAK_LIMIT_IN(dcl),
		.DC_LIMIT_IN(dcl), .OUT_BELOW_RESET_IN(brst), .OUT_BELOW_2V_IN(b2v), .SYNC_IN(sync),
		.TYPE_A_IN(typea), .STRAP_PIN_ONE_FSEL_IN(s1f), .STRAP_PIN_ONE_SS_IN(ss),
		.STRAP_PIN_ONE_DIR_IN(cdir), .STRAP_PIN_THREE_DC_LIMIT_SELECT_IN(3'h2), .STRAP_PIN_THREE_ADV_IN(2'h2),
		.CFG_WE_IN(we), .OSC_FREQ_SELECT_IN(cf), .SS_ENABLE_IN(ss), .SYNC_DIR_IN_IN(cdir),
		.DC_LIMIT_SELECT_IN(3'h5), .SOURCE_CURRENT_ADVERT_IN(2'h2), .DROOP_RESET_INHIBIT_IN(cinh),
		.FLAG_CLEAR_IN(clr), .BUCK_RUN_OUT(run), .HIGH_SIDE_OFF_OUT(hso), .ISOLATION_GATE_DRIVE_OUT(gate),
		.FAULT_N_OUT(fault_n), .OVERCURRENT_DROOP_FLAG_OUT(droop_f), .SHORT_FAULT_FLAG_OUT(short_f),
		.FORCED_PWM_OUT(fpwm), .SYNC_OUT(sync_o), .SYNC_OE_OUT(soe), .SW_CLK_OUT(swclk), .OSC_FREQ_SELECT_OUT(fsel),
		.EFF_DC_LIMIT_OUT(eff_lim), .EFF_ADVERT_OUT(eff_adv));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	// Bounded wait for the run level, then compare it
	task automatic wait_run(input logic v);
		for (int i = 0; i < 200 && run !== v; i++) cyc(1);
		chk({7'h0, v}, {7'h0, run});
	endtask : wait_run
	// One-cycle configuration write, then a quiet cycle so back-to-back writes stay apart
	task automatic cfg();
		we = 1'b1;
		cyc(1);
		we = 1'b0;
		cyc(1);
	endtask : cfg
	task automatic end_sim();
		$display("Counts: compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		cyc(3);
		rst = 1'b0;
		chk(8'h0, {5'h0, fsel});
		cyc(2);
		cfg();
		cyc(2);
		chk(8'h3, {5'h0, fsel});
		wait_run(1'b1);
		$display("test config done");
		// Enable drop: re-raising at once must not restart before the timer
		en = 1'b0;
		wait_run(1'b0);
		en = 1'b1;
		cyc(10);
		chk(8'h0, {7'h0, run});
		wait_run(1'b1);
		$display("test enable retry done");
		// Hard short: reset, pin, flag, repeated retries
		mode = 2'h2;
		wait_run(1'b0);
		cyc(1);
		chk(8'h2, {6'h0, short_f, fault_n});
		wait_run(1'b1);
		wait_run(1'b0);
		mode = 2'h0;
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		wait_run(1'b1);
		chk(8'h0, {7'h0, short_f});
		$display("test short done");
		// Droop between thresholds, reset not inhibited
		mode = 2'h1;
		cyc(20);
		chk(8'h3, {6'h0, run, hso});
		wait_run(1'b0);
		cyc(1);
		chk(8'h2, {6'h0, droop_f, fault_n});
		mode = 2'h0;
		wait_run(1'b1);
		// Same droop with the reset inhibited: flag and pin, but the stage keeps running
		clr = 1'b1;
		cinh = 1'b1;
		cfg();
		clr = 1'b0;
		mode = 2'h1;
		cyc(45);
		chk(8'h6, {5'h0, run, droop_f, fault_n});
		mode = 2'h0;
		cinh = 1'b0;
		cfg();
		$display("test droop done");
		// Short to battery holds the stage off and the gate open
		sb = 1'b1;
		cyc(6);
		chk(8'h0, {5'h0, run, gate, fault_n});
		cyc(40);
		chk(8'h0, {5'h0, run, gate, fault_n});
		sb = 1'b0;
		wait_run(1'b1);
		$display("test battery short done");
		// Thermal foldback lowers advert one step and forces limit code 1
		warn = 1'b1;
		cyc(6);
		chk({3'h0, 2'h1, DC_LIMIT_SELECT_THERMAL}, {3'h0, eff_adv, eff_lim});
		chk(8'h1, {7'h0, run});
		warn = 1'b0;
		cyc(6);
		chk(8'h15, {3'h0, eff_adv, eff_lim});
		$display("test foldback done");
		// Sync as output, then as input: level, Type-A skip and a followed clock
		cdir = 1'b0;
		cfg();
		cyc(3);
		chk(8'h7, {5'h0, soe, fpwm, sync_o ^ swclk});
		cdir = 1'b1;
		cfg();
		cyc(3);
		chk(8'h0, {7'h0, fpwm});
		typea = 1'b0;
		cyc(4);
		chk(8'h1, {7'h0, fpwm});
		typea = 1'b1;
		sync = 1'b1;
		cyc(4);
		chk(8'h1, {7'h0, fpwm});
		sync = 1'b0;
		cyc(2);
		// Period 12 cycles against a nominal 10: inside the window, yet distinct from the oscillator
		for (int i = 0; i < 16; i++) begin
			sync = ~sync;
			cyc(3);
			if (i > 11)
				chk({6'h0, sync, 1'b1}, {6'h0, swclk, fpwm});
			cyc(3);
		end
		$display("test sync done");
		// Standalone after a second reset: straps rule, writes and later strap moves do not
		sa = 1'b1;
		s1f = 3'h5;
		rst = 1'b1;
		cyc(3);
		rst = 1'b0;
		cyc(2);
		s1f = 3'h1;
		cfg();
		cyc(2);
		chk(8'h5, {5'h0, fsel});
		wait_run(1'b1);
		warn = 1'b1;
		cyc(6);
		chk(8'h9, {3'h0, eff_adv, eff_lim});
		warn = 1'b0;
		mode = 2'h1;
		cyc(45);
		chk(8'h4, {5'h0, run, droop_f, fault_n});
		mode = 2'h0;
		cyc(30);
		chk(8'h12, {3'h0, eff_adv, eff_lim});
		$display("test standalone done");
		// Over-temperature and overvoltage each stop the stage until cleared and retried
		ot = 1'b1;
		wait_run(1'b0);
		ot = 1'b0;
		wait_run(1'b1);
		ov = 1'b1;
		wait_run(1'b0);
		ov = 1'b0;
		wait_run(1'b1);
		$display("test fault done");
		end_sim();
	end
endmodule : testbench
